// ===== asmc_top.sv
// async serial modem controller: core, modem lines and register port
//
// Added by the designer: the register offsets and the address-and-strobe port.
`include "asmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module asmc_top #(
    parameter int unsigned CLK_HZ = `ASMC_CLK_HZ
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire asmc_pkg::asmc_pins_s i_pins,
    output logic o_txd,
    output logic o_cts,
    output logic o_dsr,
    output logic o_cd,
    output logic o_scd,
    output logic o_sqd,
    output logic o_ri,
    output logic o_rts,
    output logic o_dtr,
    output logic o_srts,
    output logic o_drs,
    output logic o_drs_uk
);

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int PW = $bits(asmc_pkg::asmc_pins_s);
    logic [PW-1:0] meta_ff;
    logic [PW-1:0] sync_ff;
    asmc_pkg::asmc_pins_s pin;
    logic tx_ext_q_ff;
    logic rx_ext_q_ff;

    generate
        for (genvar b = 0; b < PW; b++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_ff[b] <= 1'b1;
                    sync_ff[b] <= 1'b1;
                end else begin
                    meta_ff[b] <= i_pins[b];
                    sync_ff[b] <= meta_ff[b];
                end
            end
        end
    endgenerate

    assign pin = asmc_pkg::asmc_pins_s'(sync_ff);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_ext_q_ff <= 1'b1;
            rx_ext_q_ff <= 1'b1;
        end else begin
            tx_ext_q_ff <= pin.tx_ext_clk;
            rx_ext_q_ff <= pin.rx_ext_clk;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    asmc_pkg::asmc_mode_s mode_ff;
    logic [7:0] ctrl_ff;
    logic [3:0] aout_ff;
    logic wr_data;
    logic rd_data;
    logic wr_ctrl;

    assign wr_data = i_wr && (i_addr == `ASMC_OFF_DATA);
    assign rd_data = i_rd && (i_addr == `ASMC_OFF_DATA);
    assign wr_ctrl = i_wr && (i_addr == `ASMC_OFF_CTRL);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_ff <= asmc_pkg::asmc_mode_s'(`ASMC_MODE_RST);
            ctrl_ff <= `ASMC_CTRL_RST;
            aout_ff <= `ASMC_AOUT_RST;
        end else if (i_wr) begin
            if (i_addr == `ASMC_OFF_MODE) begin
                mode_ff <= asmc_pkg::asmc_mode_s'(i_wdata);
            end else if (i_addr == `ASMC_OFF_CTRL) begin
                ctrl_ff <= i_wdata;
            end else if (i_addr == `ASMC_OFF_AOUT) begin
                aout_ff <= i_wdata[3:0];
            end
        end
    end

    // ****************************************
    // bit clock generator
    // ****************************************
    // resolution 00 is refused: both engines stay idle
    logic res_ok;
    logic [5:0] fac_m1;
    logic [5:0] half;
    logic [21:0] div;
    logic [21:0] div_cnt_ff;
    logic gen_tick;
    logic tx_tick;
    logic rx_tick;
    logic [2:0] nbits_m1;

    function automatic logic [21:0] gen_div(input logic [3:0] sel,
                                            input logic [1:0] res);
        int unsigned baud;
        int unsigned fac;
        int unsigned q;
        case (sel)
            4'h1: baud = `ASMC_BAUD_1;
            4'h2: baud = `ASMC_BAUD_2;
            4'h3: baud = `ASMC_BAUD_3;
            4'h4: baud = `ASMC_BAUD_4;
            4'h5: baud = `ASMC_BAUD_5;
            4'h6: baud = `ASMC_BAUD_6;
            4'h7: baud = `ASMC_BAUD_7;
            4'h8: baud = `ASMC_BAUD_8;
            4'h9: baud = `ASMC_BAUD_9;
            default: baud = `ASMC_BAUD_0;
        endcase
        if (res == `ASMC_RES_X64) begin
            fac = 64;
        end else if (res == `ASMC_RES_X16) begin
            fac = 16;
        end else begin
            fac = 1;
        end
        q = CLK_HZ / (baud * fac);
        if (q == 0) begin
            q = 1;
        end
        gen_div = q[21:0];
    endfunction : gen_div

    always_comb begin
        res_ok = (mode_ff.res != 2'h0);
        if (mode_ff.res == `ASMC_RES_X64) begin
            fac_m1 = 6'h3f;
        end else if (mode_ff.res == `ASMC_RES_X16) begin
            fac_m1 = 6'h0f;
        end else begin
            fac_m1 = 6'h00;
        end
        half = fac_m1 >> 1;
        nbits_m1 = 3'h4 + {1'b0, mode_ff.len};
    end

    assign div = gen_div(pin.rate_sel, mode_ff.res);
    assign gen_tick = (div_cnt_ff >= div - 22'h1);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt_ff <= 22'h0;
        end else if (gen_tick) begin
            div_cnt_ff <= 22'h0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 22'h1;
        end
    end

    // external clocks count on their rising edges
    assign tx_tick = pin.tx_ext_sel ? (pin.tx_ext_clk && !tx_ext_q_ff)
                                    : gen_tick;
    assign rx_tick = pin.rx_ext_sel ? (pin.rx_ext_clk && !rx_ext_q_ff)
                                    : gen_tick;

    // ****************************************
    // transmitter
    // ****************************************
    asmc_pkg::asmc_tx_e tx_st_ff;
    logic [7:0] hold_ff;
    logic hold_full_ff;
    logic [7:0] tx_sh_ff;
    logic tx_par_ff;
    logic [2:0] tx_bit_ff;
    logic [5:0] tx_cnt_ff;
    logic tx_stop2_ff;
    logic tx_line;
    logic tx_take;
    logic tx_end;
    logic [7:0] len_mask;

    assign len_mask = 8'hff >> (3'h3 - {1'b0, mode_ff.len});
    assign tx_take = (tx_st_ff == asmc_pkg::TX_IDLE) && hold_full_ff &&
                     ctrl_ff[`ASMC_CTL_TXEN] && res_ok;
    assign tx_end = tx_tick && (tx_cnt_ff == fac_m1);

    // one holding register in front of the shifter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_ff <= 8'h00;
            hold_full_ff <= 1'b0;
        end else if (wr_data && (!hold_full_ff || tx_take)) begin
            hold_ff <= i_wdata;
            hold_full_ff <= 1'b1;
        end else if (tx_take) begin
            hold_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_ff <= asmc_pkg::TX_IDLE;
            tx_sh_ff <= 8'h00;
            tx_par_ff <= 1'b0;
            tx_bit_ff <= 3'h0;
            tx_cnt_ff <= 6'h00;
            tx_stop2_ff <= 1'b0;
        end else begin
            if (tx_tick) begin
                tx_cnt_ff <= tx_end ? 6'h00 : tx_cnt_ff + 6'h01;
            end
            case (tx_st_ff)
                asmc_pkg::TX_IDLE: begin
                    if (tx_take) begin
                        tx_sh_ff <= hold_ff & len_mask;
                        tx_par_ff <= (^(hold_ff & len_mask)) ^
                                     !mode_ff.even;
                        tx_cnt_ff <= 6'h00;
                        tx_st_ff <= asmc_pkg::TX_START;
                    end
                end
                asmc_pkg::TX_START: begin
                    if (tx_end) begin
                        tx_bit_ff <= 3'h0;
                        tx_st_ff <= asmc_pkg::TX_DATA;
                    end
                end
                asmc_pkg::TX_DATA: begin
                    if (tx_end) begin
                        tx_sh_ff <= tx_sh_ff >> 1;
                        tx_bit_ff <= tx_bit_ff + 3'h1;
                        if (tx_bit_ff == nbits_m1) begin
                            tx_stop2_ff <= (mode_ff.stop == `ASMC_STOP_TWO);
                            tx_st_ff <= mode_ff.par_en ? asmc_pkg::TX_PAR
                                                       : asmc_pkg::TX_STOP;
                        end
                    end
                end
                asmc_pkg::TX_PAR: begin
                    if (tx_end) begin
                        tx_st_ff <= asmc_pkg::TX_STOP;
                    end
                end
                asmc_pkg::TX_STOP: begin
                    if (tx_end) begin
                        if (tx_stop2_ff) begin
                            tx_stop2_ff <= 1'b0;
                        end else begin
                            tx_st_ff <= asmc_pkg::TX_IDLE;
                        end
                    end
                end
                default: tx_st_ff <= asmc_pkg::TX_IDLE;
            endcase
        end
    end

    always_comb begin
        case (tx_st_ff)
            asmc_pkg::TX_START: tx_line = 1'b0;
            asmc_pkg::TX_DATA: tx_line = tx_sh_ff[0];
            asmc_pkg::TX_PAR: tx_line = tx_par_ff;
            default: tx_line = 1'b1;
        endcase
    end

    // break holds the line at space regardless of the shifter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_txd <= 1'b1;
        end else begin
            o_txd <= tx_line && !ctrl_ff[`ASMC_CTL_BRK];
        end
    end

    // ****************************************
    // receiver
    // ****************************************
    asmc_pkg::asmc_rx_e rx_st_ff;
    logic [7:0] rx_sh_ff;
    logic [2:0] rx_bit_ff;
    logic [5:0] rx_cnt_ff;
    logic rx_par_bad_ff;
    logic rx_done;
    logic rx_ferr;
    logic rx_samp;
    logic [7:0] rx_word;

    assign rx_samp = rx_tick && (rx_cnt_ff == fac_m1);
    assign rx_done = (rx_st_ff == asmc_pkg::RX_STOP) && rx_samp;
    assign rx_ferr = !pin.rxd;
    assign rx_word = rx_sh_ff >> (3'h3 - {1'b0, mode_ff.len});

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_st_ff <= asmc_pkg::RX_IDLE;
            rx_sh_ff <= 8'h00;
            rx_bit_ff <= 3'h0;
            rx_cnt_ff <= 6'h00;
            rx_par_bad_ff <= 1'b0;
        end else begin
            if (rx_tick) begin
                rx_cnt_ff <= rx_samp ? 6'h00 : rx_cnt_ff + 6'h01;
            end
            case (rx_st_ff)
                asmc_pkg::RX_IDLE: begin
                    rx_cnt_ff <= 6'h00;
                    if (!pin.rxd && ctrl_ff[`ASMC_CTL_RXEN] && res_ok) begin
                        rx_st_ff <= asmc_pkg::RX_START;
                    end
                end
                asmc_pkg::RX_START: begin
                    // recheck at mid bit so a glitch is not a start
                    if (rx_tick && (rx_cnt_ff == half)) begin
                        rx_cnt_ff <= 6'h00;
                        rx_bit_ff <= 3'h0;
                        rx_par_bad_ff <= !mode_ff.even;
                        rx_st_ff <= pin.rxd ? asmc_pkg::RX_IDLE
                                            : asmc_pkg::RX_DATA;
                    end
                end
                asmc_pkg::RX_DATA: begin
                    if (rx_samp) begin
                        rx_sh_ff <= {pin.rxd, rx_sh_ff[7:1]};
                        rx_par_bad_ff <= rx_par_bad_ff ^ pin.rxd;
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == nbits_m1) begin
                            rx_st_ff <= mode_ff.par_en ? asmc_pkg::RX_PAR
                                                       : asmc_pkg::RX_STOP;
                        end
                    end
                end
                asmc_pkg::RX_PAR: begin
                    if (rx_samp) begin
                        rx_par_bad_ff <= rx_par_bad_ff ^ pin.rxd;
                        rx_st_ff <= asmc_pkg::RX_STOP;
                    end
                end
                asmc_pkg::RX_STOP: begin
                    if (rx_samp) begin
                        rx_st_ff <= asmc_pkg::RX_IDLE;
                    end
                end
                default: rx_st_ff <= asmc_pkg::RX_IDLE;
            endcase
        end
    end

    // ****************************************
    // receive buffer and error flags
    // ****************************************
    logic [7:0] rx_buf_ff;
    logic rx_rdy_ff;
    logic perr_ff;
    logic ferr_ff;
    logic ovr_ff;
    logic err_clr;
    logic rx_full;

    assign err_clr = wr_ctrl && i_wdata[`ASMC_CTL_ERST];
    assign rx_full = rx_rdy_ff && !rd_data;

    // a fresh character set wins over the read that drains it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_buf_ff <= 8'h00;
            rx_rdy_ff <= 1'b0;
        end else if (rx_done && !rx_full) begin
            rx_buf_ff <= rx_word;
            rx_rdy_ff <= 1'b1;
        end else if (rd_data) begin
            rx_rdy_ff <= 1'b0;
        end
    end

    // the unread character is kept; the newcomer is dropped
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovr_ff <= 1'b0;
        end else if (rx_done && rx_full) begin
            ovr_ff <= 1'b1;
        end else if (err_clr) begin
            ovr_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            perr_ff <= 1'b0;
            ferr_ff <= 1'b0;
        end else begin
            if (rx_done && mode_ff.par_en && rx_par_bad_ff) begin
                perr_ff <= 1'b1;
            end else if (err_clr) begin
                perr_ff <= 1'b0;
            end
            if (rx_done && rx_ferr) begin
                ferr_ff <= 1'b1;
            end else if (err_clr) begin
                ferr_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // modem lines and status words
    // ****************************************
    logic [7:0] stat;
    logic [7:0] ain;

    always_comb begin
        stat = 8'h00;
        stat[`ASMC_ST_TXRDY] = !hold_full_ff;
        stat[`ASMC_ST_RXRDY] = rx_rdy_ff;
        stat[`ASMC_ST_TXEMP] = !hold_full_ff &&
                               (tx_st_ff == asmc_pkg::TX_IDLE);
        stat[`ASMC_ST_PERR] = perr_ff;
        stat[`ASMC_ST_OVR] = ovr_ff;
        stat[`ASMC_ST_FERR] = ferr_ff;
        stat[`ASMC_ST_LINE7] = pin.data_terminal_side ? pin.cts
                                       : pin.rts;
        ain = 8'h00;
        if (pin.data_terminal_side) begin
            ain[1] = pin.ri;
            ain[2] = pin.scd;
        end else begin
            // the line itself never reaches the register
            ain[0] = pin.srts_force;
            ain[1] = pin.drs;
        end
    end

    // each side's lines idle low while the other side is cabled
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cts <= 1'b0;
            o_dsr <= 1'b0;
            o_cd <= 1'b0;
            o_scd <= 1'b0;
            o_sqd <= 1'b0;
            o_ri <= 1'b0;
        end else begin
            o_cts <= !pin.data_terminal_side && ctrl_ff[`ASMC_CTL_LINE5];
            o_dsr <= !pin.data_terminal_side && ctrl_ff[`ASMC_CTL_LINE1];
            o_cd <= !pin.data_terminal_side && aout_ff[0];
            o_scd <= !pin.data_terminal_side && aout_ff[1];
            o_sqd <= !pin.data_terminal_side && aout_ff[2];
            o_ri <= !pin.data_terminal_side && aout_ff[3];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rts <= 1'b0;
            o_dtr <= 1'b0;
            o_srts <= 1'b0;
            o_drs <= 1'b0;
            o_drs_uk <= 1'b0;
        end else begin
            o_rts <= pin.data_terminal_side && ctrl_ff[`ASMC_CTL_LINE5];
            o_dtr <= pin.data_terminal_side && ctrl_ff[`ASMC_CTL_LINE1];
            o_srts <= pin.data_terminal_side && aout_ff[0];
            o_drs <= pin.data_terminal_side && aout_ff[1];
            o_drs_uk <= pin.data_terminal_side && aout_ff[2];
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // data stands one cycle only; unmapped offsets read zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (!i_rd) begin
            o_rdata <= 8'h00;
        end else if (i_addr == `ASMC_OFF_DATA) begin
            o_rdata <= rx_buf_ff;
        end else if (i_addr == `ASMC_OFF_MODE) begin
            o_rdata <= mode_ff;
        end else if (i_addr == `ASMC_OFF_CTRL) begin
            o_rdata <= ctrl_ff;
        end else if (i_addr == `ASMC_OFF_STAT) begin
            o_rdata <= stat;
        end else if (i_addr == `ASMC_OFF_AOUT) begin
            o_rdata <= {4'h0, aout_ff};
        end else if (i_addr == `ASMC_OFF_AIN) begin
            o_rdata <= ain;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule : asmc_top

`default_nettype wire

// ===== asmc_cfg.svh
// constants for the async serial modem controller
`ifndef ASMC_CFG_SVH
`define ASMC_CFG_SVH

// register offsets on the software port
`define ASMC_OFF_DATA 3'h0
`define ASMC_OFF_MODE 3'h1
`define ASMC_OFF_CTRL 3'h2
`define ASMC_OFF_STAT 3'h3
`define ASMC_OFF_AOUT 3'h4
`define ASMC_OFF_AIN 3'h5

// core control word bits
`define ASMC_CTL_TXEN 0
`define ASMC_CTL_LINE1 1
`define ASMC_CTL_RXEN 2
`define ASMC_CTL_BRK 3
`define ASMC_CTL_ERST 4
`define ASMC_CTL_LINE5 5

// core status word bits
`define ASMC_ST_TXRDY 0
`define ASMC_ST_RXRDY 1
`define ASMC_ST_TXEMP 2
`define ASMC_ST_PERR 3
`define ASMC_ST_OVR 4
`define ASMC_ST_FERR 5
`define ASMC_ST_LINE7 7

// reset values: 2 stop, no parity, 8 bits, 1/64 resolution
`define ASMC_MODE_RST 8'hcf
`define ASMC_CTRL_RST 8'h00
`define ASMC_AOUT_RST 4'h0

// resolution codes in the low two mode bits; the two-stop code in the top two
`define ASMC_RES_X1 2'h1
`define ASMC_RES_X16 2'h2
`define ASMC_RES_X64 2'h3
`define ASMC_STOP_TWO 2'h3

// bit rates, selected by the rate switch positions 1..9 and 0
`define ASMC_CLK_HZ 200000000
`define ASMC_BAUD_1 9600
`define ASMC_BAUD_2 4800
`define ASMC_BAUD_3 2400
`define ASMC_BAUD_4 1800
`define ASMC_BAUD_5 1200
`define ASMC_BAUD_6 600
`define ASMC_BAUD_7 300
`define ASMC_BAUD_8 150
`define ASMC_BAUD_9 110
`define ASMC_BAUD_0 75

`endif

// ===== asmc_pkg.sv
// types shared by the async serial modem controller
package asmc_pkg;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PAR = 5'b01000,
        TX_STOP = 5'b10000
    } asmc_tx_e;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } asmc_rx_e;

    // mode word layout, msb first
    typedef struct packed {
        logic [1:0] stop;
        logic even;
        logic par_en;
        logic [1:0] len;
        logic [1:0] res;
    } asmc_mode_s;

    // every pin and switch that arrives from outside the clock domain
    typedef struct packed {
        logic rxd;
        logic rts;
        logic cts;
        logic drs;
        logic ri;
        logic scd;
        logic tx_ext_clk;
        logic rx_ext_clk;
        logic data_terminal_side;
        logic tx_ext_sel;
        logic rx_ext_sel;
        logic srts_force;
        logic [3:0] rate_sel;
    } asmc_pins_s;

endpackage : asmc_pkg

// ===== asmc_top_asserts.sv
// port-level assertions for the async serial modem controller
`timescale 1ns/1ps
`default_nettype none
module asmc_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire asmc_pkg::asmc_pins_s i_pins,
    input wire logic o_cts,
    input wire logic o_dsr,
    input wire logic o_cd,
    input wire logic o_scd,
    input wire logic o_sqd,
    input wire logic o_ri,
    input wire logic o_rts,
    input wire logic o_dtr,
    input wire logic o_srts,
    input wire logic o_drs,
    input wire logic o_drs_uk
);
    // pins other than the data line must sit still past the synchronisers
    logic [44:0] hist_ff;
    logic sd;
    logic td;
    logic [1:0] wsel;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hist_ff <= '1;
        end else begin
            hist_ff <= {hist_ff[29:0], i_pins[14:0]};
        end
    end
    assign sd = hist_ff == {3{i_pins[14:0]}} && !i_pins.data_terminal_side;
    assign td = hist_ff == {3{i_pins[14:0]}} && i_pins.data_terminal_side;
    assign wsel = {i_wdata[5], i_wdata[1]};
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_set_ctrl: assert property (
        i_wr && i_addr == 3'h2 && sd |-> ##2 {o_cts, o_dsr} == $past(wsel, 2))
        else $error("set side ctrl lines wrong");
    a_set_aux: assert property (
        i_wr && i_addr == 3'h4 && sd |-> ##2
        {o_ri, o_sqd, o_scd, o_cd} == $past(i_wdata[3:0], 2))
        else $error("set side aux lines wrong");
    a_term_ctrl: assert property (
        i_wr && i_addr == 3'h2 && td |-> ##2 {o_rts, o_dtr} == $past(wsel, 2))
        else $error("terminal ctrl lines wrong");
    a_term_aux: assert property (
        i_wr && i_addr == 3'h4 && td |-> ##2
        {o_drs_uk, o_drs, o_srts} == $past(i_wdata[2:0], 2))
        else $error("terminal aux lines wrong");
    a_line7_set: assert property (
        i_rd && i_addr == 3'h3 && sd |=> o_rdata[7] == $past(i_pins.rts))
        else $error("status bit 7 wrong on set side");
    a_line7_term: assert property (
        i_rd && i_addr == 3'h3 && td |=> o_rdata[7] == $past(i_pins.cts))
        else $error("status bit 7 wrong on terminal side");
    a_ain_set: assert property (
        i_rd && i_addr == 3'h5 && sd |=>
        o_rdata[1:0] == {$past(i_pins.drs), $past(i_pins.srts_force)})
        else $error("aux in wrong on set side");
    a_ain_term: assert property (
        i_rd && i_addr == 3'h5 && td |=>
        o_rdata[2:1] == {$past(i_pins.scd), $past(i_pins.ri)})
        else $error("aux in wrong on terminal side");
    c_set_wr: cover property (i_wr && i_addr == 3'h4 && sd);
    c_term_wr: cover property (i_wr && i_addr == 3'h2 && td);
    c_term_rd: cover property (i_rd && i_addr == 3'h5 && td);
endmodule : asmc_chk
bind asmc_top asmc_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_pins(i_pins), .o_cts(o_cts), .o_dsr(o_dsr),
    .o_cd(o_cd), .o_scd(o_scd), .o_sqd(o_sqd), .o_ri(o_ri), .o_rts(o_rts),
    .o_dtr(o_dtr), .o_srts(o_srts), .o_drs(o_drs), .o_drs_uk(o_drs_uk));
`default_nettype wire

// ===== asmc_far.sv
// far-side terminal or modem model with its line looped back
`timescale 1ns/1ps
`default_nettype none
module asmc_far (
    input wire logic i_txd,
    input wire logic i_dte,
    input wire logic [4:0] i_lvl,
    input wire logic i_esel,
    input wire logic i_eclk,
    output var asmc_pkg::asmc_pins_s o_pins
);
    // local loop: every sent character comes straight back
    always_comb begin
        o_pins = '0;
        o_pins.rxd = i_txd;
        o_pins.data_terminal_side = i_dte;
        {o_pins.rts, o_pins.cts, o_pins.drs, o_pins.ri, o_pins.scd} = i_lvl;
        o_pins.srts_force = !i_dte;
        o_pins.tx_ext_clk = i_eclk;
        o_pins.rx_ext_clk = i_eclk;
        o_pins.tx_ext_sel = i_esel;
        o_pins.rx_ext_sel = i_esel;
        o_pins.rate_sel = 4'h1;
    end
endmodule : asmc_far
`default_nettype wire

// ===== tb_async_serial_modem_ctrl.sv
// self-checking bench for the async serial modem controller
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_modem_ctrl;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic data_terminal_side = 1'b0; // the set side is cabled first, then the terminal side
    logic esel = 1'b0;
    logic [3:0] ediv = 4'h0;
    logic [4:0] lvl = 5'h00;
    logic [7:0] rdata;
    logic [7:0] got;
    wire [10:0] mo;
    logic txd;
    asmc_pkg::asmc_pins_s pins;
    int fails = 0;
    int num_checks = 0;
    asmc_far far (.i_txd(txd), .i_dte(data_terminal_side), .i_lvl(lvl), .i_esel(esel),
        .i_eclk(ediv[3]), .o_pins(pins));
    // slow clock figure keeps a bit at 320 cycles
    asmc_top #(.CLK_HZ(32'h002ee000)) dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_pins(pins), .o_txd(txd), .o_cts(mo[10]),
        .o_dsr(mo[9]), .o_cd(mo[8]), .o_scd(mo[7]), .o_sqd(mo[6]),
        .o_ri(mo[5]), .o_rts(mo[4]), .o_dtr(mo[3]), .o_srts(mo[2]),
        .o_drs(mo[1]), .o_drs_uk(mo[0]));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // the external bit clock stands still until it is selected
    always @(posedge clk) begin
        if (esel) begin
            ediv <= ediv + 4'h1;
        end
    end
    task automatic chk(input string nm, input logic [10:0] s,
        input logic [10:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rchk(input string nm, input logic [2:0] a,
        input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        got = rdata;
        if (nm != "") chk(nm, {3'h0, got & m}, {3'h0, e});
    endtask : rchk
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    task automatic poll(input int b);
        got = 8'h00;
        for (int n = 0; n < 5000 && got[b] !== 1'b1; n++)
            rchk("", 3'h3, 8'h00, 8'h00);
        chk("flag", {10'h000, got[b]}, 11'h001);
    endtask : poll
    task automatic test_done();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rchk("mode", 3'h1, 8'hff, 8'hcf);
        rchk("ctrl", 3'h2, 8'hff, 8'h00);
        rchk("aout", 3'h4, 8'h0f, 8'h00);
        rchk("gap", 3'h6, 8'hff, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wreg(3'h4, 8'h01 << i);
            settle();
            chk("aux", mo, 11'h100 >> i);
        end
        wreg(3'h2, 8'h22);
        settle();
        chk("ctl", mo, 11'h620);
        for (int j = 0; j < 2; j++) begin
            lvl <= j ? 5'h14 : 5'h00;
            settle();
            rchk("rts", 3'h3, 8'h80, j ? 8'h80 : 8'h00);
            rchk("ain", 3'h5, 8'h03, j ? 8'h03 : 8'h01);
        end
        data_terminal_side <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wreg(3'h4, 8'h01 << i);
            settle();
            chk("taux", mo, 11'h018 | (11'h004 >> i));
        end
        for (int j = 0; j < 2; j++) begin
            lvl <= j ? 5'h0b : 5'h02;
            settle();
            rchk("cts", 3'h3, 8'h80, j ? 8'h80 : 8'h00);
            rchk("tain", 3'h5, 8'h06, j ? 8'h06 : 8'h02);
        end
        wreg(3'h2, 8'h05);
        wreg(3'h0, 8'ha5);
        poll(1);
        rchk("rx", 3'h0, 8'hff, 8'ha5);
        rchk("rdy", 3'h3, 8'h12, 8'h00);
        wreg(3'h0, 8'h3c);
        poll(0);
        wreg(3'h0, 8'hc3);
        poll(4);
        rchk("old", 3'h0, 8'hff, 8'h3c);
        wreg(3'h2, 8'h15);
        rchk("clr", 3'h3, 8'h10, 8'h00);
        poll(2);
        wreg(3'h1, 8'h5a);
        wreg(3'h0, 8'hc5);
        poll(1);
        rchk("rx7", 3'h0, 8'hff, 8'h45);
        rchk("err", 3'h3, 8'h38, 8'h00);
        poll(2);
        esel <= 1'b1;
        wreg(3'h0, 8'h3a);
        poll(1);
        rchk("ext", 3'h0, 8'hff, 8'h3a);
        poll(2);
        wreg(3'h1, 8'h58);
        wreg(3'h0, 8'h11);
        settle();
        rchk("res0", 3'h3, 8'h05, 8'h00);
        test_done();
    end
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule : tb_async_serial_modem_ctrl
`default_nettype wire
